// ---- inc/gii_cfg.svh ----
// Constants of the bus instrument interface: addresses, command codes, timing and sizes.
`ifndef GII_CFG_SVH
`define GII_CFG_SVH
`define GII_ADDR_DEFAULT 6'h1c
`define GII_ADDR_MAX     6'h1e
`define GII_TON_FIRST    6'h28
`define GII_TON_LAST     6'h2b
`define GII_GRP_MASK     7'h60
`define GII_GRP_LISTEN   7'h20
`define GII_GRP_TALK     7'h40
`define GII_CMD_UNL      7'h3f
`define GII_CMD_GTL      7'h01
`define GII_CMD_SDC      7'h04
`define GII_CMD_GET      7'h08
`define GII_CMD_LLO      7'h11
`define GII_CMD_DCL      7'h14
`define GII_CMD_SPE      7'h18
`define GII_CMD_SPD      7'h19
`define GII_CLK_NS       10
`define GII_SETTLE_NS    2000
`define GII_SETTLE_CYC   ((`GII_SETTLE_NS + `GII_CLK_NS - 1) / `GII_CLK_NS)
`define GII_FIFO_DEPTH   32
`define GII_FIFO_AW      5
`endif

// ---- inc/gii_pkg.sv ----
// Types shared by the bus instrument interface modules.
package gii_pkg;
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } gii_byte_type;
  typedef enum logic [1:0] {
    SH_IDLE = 2'h0, SH_SETTLE = 2'h1, SH_WAIT_RDY = 2'h2, SH_DAV = 2'h3
  } gii_sh_state_type;
  typedef enum logic [1:0] {
    AH_IDLE = 2'h0, AH_WAIT = 2'h1, AH_READY = 2'h2, AH_HOLD = 2'h3
  } gii_ah_state_type;
  typedef struct packed {
    gii_sh_state_type state;
    logic [7:0]       cnt;
    logic [7:0]       dio_oe_n;
    logic             dav_oe_n;
    logic             eoi_oe_n;
    logic             take;
  } gii_sh_st_type;
  typedef struct packed {
    logic [5:0]       addr;
    logic             ton;
    logic             talk;
    logic             listen;
    logic             spoll;
    logic             remote;
    logic             llo;
    logic             panel_lock;
    logic             pending;
    gii_ah_state_type ah;
    logic             nrfd_oe_n;
    logic             ndac_oe_n;
    logic             srq_oe_n;
    logic             rx_valid;
    gii_byte_type     rx_byte;
    logic             dev_clear;
    logic             trigger;
  } gii_main_st_type;
endpackage

// ---- design/gii_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides and a flush.
`timescale 1ns/1ps
`default_nettype none
`include "gii_cfg.svh"
module gii_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = `GII_FIFO_DEPTH,
  parameter int AW    = `GII_FIFO_AW
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } gii_fifo_st_type;
  gii_fifo_st_type  st;
  gii_fifo_st_type  next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;
  assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data  = mem[st.rd];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;
  always_comb begin
    next_st = st;
    if (flush) begin
      next_st = '0;
    end else begin
      if (push) next_st.wr = st.wr + AW'(1);
      if (pop) next_st.rd = st.rd + AW'(1);
      next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st <= '0;
    else st <= next_st;
  end
  // The storage has no reset so that it can map onto plain RAM.
  always_ff @(posedge clk) begin
    if (push) mem[st.wr] <= in_data;
  end
endmodule // gii_fifo
`default_nettype wire

// ---- design/gii_sh.sv ----
// Source handshake: drives one byte, waits for readiness, raises DAV, waits for acceptance.
`timescale 1ns/1ps
`default_nettype none
`include "gii_cfg.svh"
module gii_sh
  import gii_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  input  wire logic         src_valid,
  input  wire gii_byte_type src_byte,
  output logic              src_take,
  input  wire logic         nrfd_in,
  input  wire logic         ndac_in,
  output logic [7:0]        dio_oe_n,
  output logic              dav_oe_n,
  output logic              eoi_oe_n
);
  gii_sh_st_type st;
  gii_sh_st_type next_st;
  always_comb begin
    next_st = st;
    next_st.take = 1'b0;
    if (!en) begin
      next_st.state = SH_IDLE;
      next_st.dio_oe_n = 8'hff;
      next_st.dav_oe_n = 1'b1;
      next_st.eoi_oe_n = 1'b1;
    end else begin
      case (st.state)
        SH_IDLE: if (src_valid && !st.take) begin
          next_st.dio_oe_n = ~src_byte.data;
          next_st.eoi_oe_n = ~src_byte.last;
          next_st.cnt = 8'(`GII_SETTLE_CYC);
          next_st.state = SH_SETTLE;
        end
        SH_SETTLE: begin
          next_st.cnt = st.cnt - 8'h01;
          if (st.cnt == 8'h01) next_st.state = SH_WAIT_RDY;
        end
        SH_WAIT_RDY: if (nrfd_in) begin
          next_st.dav_oe_n = 1'b0;
          next_st.state = SH_DAV;
        end
        SH_DAV: if (ndac_in) begin
          next_st.dav_oe_n = 1'b1;
          next_st.dio_oe_n = 8'hff;
          next_st.eoi_oe_n = 1'b1;
          next_st.take = 1'b1;
          next_st.state = SH_IDLE;
        end
        default: next_st.state = SH_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{state: SH_IDLE, dio_oe_n: 8'hff, dav_oe_n: 1'b1, eoi_oe_n: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end
  assign src_take = st.take;
  assign dio_oe_n = st.dio_oe_n;
  assign dav_oe_n = st.dav_oe_n;
  assign eoi_oe_n = st.eoi_oe_n;
  a_dav_ready: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(dav_oe_n) |-> $past(nrfd_in) && $past(dio_oe_n, 2) == dio_oe_n)
    else $error("DAV raised without ready or settled data");
  a_dav_held: assert property (@(posedge clk) disable iff (!rst_n)
    !dav_oe_n && !ndac_in && en |=> !dav_oe_n || !en)
    else $error("DAV dropped before acceptance");
endmodule // gii_sh
`default_nettype wire

// ---- design/gii_top.sv ----
// Bus instrument interface: addressing, acceptor handshake, poll, remote state and clear.
`timescale 1ns/1ps
`default_nettype none
`include "gii_cfg.svh"
module gii_top
  import gii_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [7:0]   dio_in,
  output logic      [7:0]   dio_out,
  output logic      [7:0]   dio_oe_n,
  input  wire logic         dav_in,
  output logic              dav_out,
  output logic              dav_oe_n,
  input  wire logic         nrfd_in,
  output logic              nrfd_out,
  output logic              nrfd_oe_n,
  input  wire logic         ndac_in,
  output logic              ndac_out,
  output logic              ndac_oe_n,
  input  wire logic         eoi_in,
  output logic              eoi_out,
  output logic              eoi_oe_n,
  output logic              srq_out,
  output logic              srq_oe_n,
  input  wire logic         atn_in,
  input  wire logic         ifc_in,
  input  wire logic         ren_in,
  input  wire logic         addr_wr,
  input  wire logic [5:0]   addr_set,
  input  wire logic         tx_valid,
  input  wire gii_byte_type tx_byte,
  output logic              tx_ready,
  output logic              rx_valid,
  output gii_byte_type      rx_byte,
  input  wire logic         rx_ready,
  input  wire logic         svc_req,
  input  wire logic [7:0]   stb_in,
  output logic              dev_clear,
  output logic              trigger,
  output logic              remote,
  output logic              panel_lock,
  output logic              talk_active,
  output logic              listen_active,
  output logic              talk_only
);
  gii_main_st_type st;
  gii_main_st_type next_st;
  logic            atn;
  logic            ifc;
  logic            ren;
  logic            dav;
  logic [6:0]      cmd;
  logic            engaged;
  logic            capture;
  logic            cmd_take;
  logic            mla_hit;
  logic            mta_hit;
  logic            talk_en;
  logic            poll_src;
  logic            src_valid;
  gii_byte_type    src_byte;
  logic            sh_take;
  logic            fifo_valid;
  gii_byte_type    fifo_byte;

  function automatic logic gii_is_ton(input logic [5:0] a);
    return (a >= `GII_TON_FIRST) && (a <= `GII_TON_LAST);
  endfunction

  function automatic logic gii_addr_ok(input logic [5:0] a);
    return (a <= `GII_ADDR_MAX) || gii_is_ton(a);
  endfunction

  // Every bus line is true when low.
  assign atn = !atn_in;
  assign ifc = !ifc_in;
  assign ren = !ren_in;
  assign dav = !dav_in;
  assign cmd = ~dio_in[6:0];

  // Under ATN the acceptor always listens; otherwise only while addressed.
  assign engaged  = atn || (st.listen && !st.ton);
  assign capture  = engaged && (st.ah == AH_READY) && dav && (atn || !st.rx_valid);
  assign cmd_take = capture && atn;
  assign mla_hit  = cmd_take && !st.ton &&
                    (cmd == (`GII_GRP_LISTEN | {2'h0, st.addr[4:0]}));
  assign mta_hit  = cmd_take && !st.ton &&
                    (cmd == (`GII_GRP_TALK | {2'h0, st.addr[4:0]}));

  // The source releases its lines at the first clock edge under ATN, so a poll identify finds the data lines free.
  assign talk_en  = !atn && (st.talk || st.ton);
  assign poll_src = st.spoll && st.talk;
  assign src_valid = poll_src || fifo_valid;
  assign src_byte  = poll_src ?
                     gii_byte_type'{last: 1'b0, data: {stb_in[7], st.pending, stb_in[5:0]}}
                     : fifo_byte;

  gii_fifo #(
    .WIDTH ($bits(gii_byte_type))
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (st.dev_clear),
    .in_valid  (tx_valid),
    .in_data   (tx_byte),
    .in_ready  (tx_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_byte),
    .out_ready (sh_take && !poll_src)
  );

  gii_sh u_sh (
    .clk       (clk),
    .rst_n     (rst_n),
    .en        (talk_en),
    .src_valid (src_valid),
    .src_byte  (src_byte),
    .src_take  (sh_take),
    .nrfd_in   (nrfd_in),
    .ndac_in   (ndac_in),
    .dio_oe_n  (dio_oe_n),
    .dav_oe_n  (dav_oe_n),
    .eoi_oe_n  (eoi_oe_n)
  );

  always_comb begin
    next_st = st;
    next_st.dev_clear = 1'b0;
    next_st.trigger = 1'b0;
    if (addr_wr && gii_addr_ok(addr_set)) begin
      next_st.addr = addr_set;
      next_st.talk = 1'b0;
      next_st.listen = 1'b0;
    end
    if (st.rx_valid && rx_ready) next_st.rx_valid = 1'b0;
    if (!engaged) begin
      next_st.ah = AH_IDLE;
      next_st.nrfd_oe_n = 1'b1;
      next_st.ndac_oe_n = 1'b1;
    end else begin
      case (st.ah)
        AH_IDLE: begin
          next_st.ah = AH_WAIT;
          next_st.nrfd_oe_n = 1'b0;
          next_st.ndac_oe_n = 1'b0;
        end
        AH_WAIT: if (!dav && (atn || !st.rx_valid)) begin
          next_st.ah = AH_READY;
          next_st.nrfd_oe_n = 1'b1;
        end
        AH_READY: if (capture) begin
          next_st.ah = AH_HOLD;
          next_st.nrfd_oe_n = 1'b0;
          next_st.ndac_oe_n = 1'b1;
        end else if (!atn && st.rx_valid) begin
          next_st.ah = AH_WAIT;
          next_st.nrfd_oe_n = 1'b0;
        end
        AH_HOLD: if (!dav) begin
          next_st.ah = AH_WAIT;
          next_st.ndac_oe_n = 1'b0;
        end
        default: next_st.ah = AH_IDLE;
      endcase
    end
    if (capture && !atn) begin
      next_st.rx_valid = 1'b1;
      next_st.rx_byte = '{last: !eoi_in, data: ~dio_in};
    end
    // Secondary addresses and poll configuration fall through untouched.
    if (cmd_take) begin
      if (mla_hit) begin
        next_st.listen = 1'b1;
        next_st.talk = 1'b0;
        if (ren) next_st.remote = 1'b1;
      end else if (cmd == `GII_CMD_UNL) begin
        next_st.listen = 1'b0;
      end else if (mta_hit) begin
        next_st.talk = 1'b1;
        next_st.listen = 1'b0;
      end else if ((cmd & `GII_GRP_MASK) == `GII_GRP_TALK) begin
        next_st.talk = 1'b0;
      end else if (cmd == `GII_CMD_GTL && st.listen) begin
        next_st.remote = 1'b0;
      end else if ((cmd == `GII_CMD_SDC && st.listen) || cmd == `GII_CMD_DCL) begin
        next_st.dev_clear = 1'b1;
      end else if (cmd == `GII_CMD_GET && st.listen) begin
        next_st.trigger = 1'b1;
      end else if (cmd == `GII_CMD_LLO) begin
        next_st.llo = 1'b1;
      end else if (cmd == `GII_CMD_SPE) begin
        next_st.spoll = 1'b1;
      end else if (cmd == `GII_CMD_SPD) begin
        next_st.spoll = 1'b0;
      end
    end
    if (sh_take && poll_src) next_st.pending = 1'b0;
    if (next_st.dev_clear) next_st.pending = 1'b0;
    // A new request in the clearing cycle survives.
    if (svc_req) next_st.pending = 1'b1;
    if (!ren) begin
      next_st.remote = 1'b0;
      next_st.llo = 1'b0;
    end
    if (ifc) begin
      next_st.talk = 1'b0;
      next_st.listen = 1'b0;
      next_st.spoll = 1'b0;
      next_st.remote = 1'b0;
    end
    next_st.ton = gii_is_ton(next_st.addr);
    if (next_st.ton) next_st.listen = 1'b0;
    next_st.srq_oe_n = !next_st.pending;
    next_st.panel_lock = next_st.remote && next_st.llo;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{addr: `GII_ADDR_DEFAULT, ah: AH_IDLE, nrfd_oe_n: 1'b1,
              ndac_oe_n: 1'b1, srq_oe_n: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Drivers only ever pull low; the enable alone decides the line.
  assign dio_out  = 8'h00;
  assign dav_out  = 1'b0;
  assign nrfd_out = 1'b0;
  assign ndac_out = 1'b0;
  assign eoi_out  = 1'b0;
  assign srq_out  = 1'b0;
  assign nrfd_oe_n     = st.nrfd_oe_n;
  assign ndac_oe_n     = st.ndac_oe_n;
  assign srq_oe_n      = st.srq_oe_n;
  assign rx_valid      = st.rx_valid;
  assign rx_byte       = st.rx_byte;
  assign dev_clear     = st.dev_clear;
  assign trigger       = st.trigger;
  assign remote        = st.remote;
  assign panel_lock    = st.panel_lock;
  assign talk_active   = st.talk;
  assign listen_active = st.listen;
  assign talk_only     = st.ton;

  a_ppoll_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    atn && $past(atn) |-> dio_oe_n == 8'hff)
    else $error("data lines driven under ATN");
  a_talk_gate: assert property (@(posedge clk) disable iff (!rst_n)
    dio_oe_n != 8'hff |-> $past(talk_en))
    else $error("data driven while not talker");
  a_listen_gate: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rx_valid) |-> $past(st.listen) && !$past(atn) && $past(st.ah) == AH_READY)
    else $error("data byte taken while not listener");
  a_ah_hold_nrfd: assert property (@(posedge clk) disable iff (!rst_n)
    st.ah == AH_HOLD |-> !nrfd_oe_n && ndac_oe_n)
    else $error("acceptor hold state lines wrong");
  a_mla_untalk: assert property (@(posedge clk) disable iff (!rst_n)
    mla_hit && !ifc |=> listen_active && !talk_active)
    else $error("own listen address kept talker");
  a_mta_unlisten: assert property (@(posedge clk) disable iff (!rst_n)
    mta_hit && !ifc |=> talk_active && !listen_active)
    else $error("own talk address kept listener");
  a_ifc_idle: assert property (@(posedge clk) disable iff (!rst_n)
    ifc |=> !talk_active && !listen_active && !remote)
    else $error("interface clear left addressed state");
  a_ren_remote: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(remote) |-> $past(ren) && $past(mla_hit))
    else $error("remote entered without REN and listen address");
  a_srq_on: assert property (@(posedge clk) disable iff (!rst_n)
    svc_req |=> !srq_oe_n ##0 st.pending)
    else $error("service request not raised");
  a_poll_clear: assert property (@(posedge clk) disable iff (!rst_n)
    sh_take && poll_src && !svc_req |=> srq_oe_n)
    else $error("pending request survived serial poll");
  a_panel_lock: assert property (@(posedge clk) disable iff (!rst_n)
    st.llo && mla_hit && ren && !ifc |=> panel_lock)
    else $error("lockout not applied in remote");

  // Command decoding must leave these traces one edge after the byte is taken; the role, REN, address and receive hold checks apply at every edge.
  a_unl_drop: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_take && cmd == `GII_CMD_UNL |=> !listen_active)
    else $error("unlisten kept listener");
  a_untalk_other: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_take && (cmd & `GII_GRP_MASK) == `GII_GRP_TALK && !mta_hit |=> !talk_active)
    else $error("other talk address kept talker");
  a_roles_apart: assert property (@(posedge clk) disable iff (!rst_n)
    !(talk_active && listen_active))
    else $error("talker and listener at once");
  a_sdc_clear: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_take && cmd == `GII_CMD_SDC && st.listen |=> dev_clear)
    else $error("selected clear lost");
  a_dcl_clear: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_take && cmd == `GII_CMD_DCL |=> dev_clear)
    else $error("universal clear lost");
  a_get_trig: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_take && cmd == `GII_CMD_GET && st.listen |=> trigger)
    else $error("trigger lost");
  a_trig_source: assert property (@(posedge clk) disable iff (!rst_n)
    trigger |-> $past(st.listen) && $past(cmd_take))
    else $error("trigger without addressed command");
  a_llo_set: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_take && cmd == `GII_CMD_LLO && ren |=> st.llo)
    else $error("lockout not stored");
  a_ren_local: assert property (@(posedge clk) disable iff (!rst_n)
    !ren |=> !remote && !panel_lock)
    else $error("remote kept without REN");
  a_addr_legal: assert property (@(posedge clk) disable iff (!rst_n)
    st.addr <= `GII_ADDR_MAX || talk_only)
    else $error("address outside legal settings");
  a_ton_deaf: assert property (@(posedge clk) disable iff (!rst_n)
    talk_only |-> !listen_active)
    else $error("listener in talk-only");
  a_rx_hold: assert property (@(posedge clk) disable iff (!rst_n)
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_byte))
    else $error("unread byte lost");
endmodule // gii_top
`default_nettype wire

// ---- verification/gii_ctrl_model.sv ----
// Bus controller model: source and acceptor handshake plus ATN, IFC and REN.
`timescale 1ns/1ps
`default_nettype none
module gii_ctrl_model (
  input  wire logic       clk,
  input  wire logic [7:0] dio_w,
  input  wire logic       dav_w,
  input  wire logic       nrfd_w,
  input  wire logic       ndac_w,
  input  wire logic       eoi_w,
  output var logic  [7:0] dio_p,
  output var logic        dav_p,
  output var logic        nrfd_p,
  output var logic        ndac_p,
  output var logic        eoi_p,
  output var logic        atn_p,
  output var logic        ifc_p,
  output var logic        ren_p
);
  int stalls = 0;
  // A pull of 1 holds its line low; released lines float up to the pull-up.
  initial begin
    {dio_p, dav_p, eoi_p, atn_p, ifc_p, ren_p} = '0;
    {nrfd_p, ndac_p} = 2'h3;
  end
  // A wait that runs out is a failure, not a silent fall-through.
  task automatic stall(input string m);
    stalls++;
    $display("mismatch %0t %s stalled", $time, m);
  endtask
  // Idle acceptor holds NRFD and NDAC so a talking device cannot lose bytes.
  task automatic send_byte(input logic atn, input logic [7:0] d, input logic last);
    @(negedge clk);
    {nrfd_p, ndac_p} = 2'h0;
    atn_p = atn;
    dio_p = d;
    eoi_p = last;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 4000 && nrfd_w !== 1'b1; i++) @(negedge clk);
    if (nrfd_w !== 1'b1) stall("ready");
    dav_p = 1'b1;
    for (int i = 0; i < 4000 && ndac_w !== 1'b1; i++) @(negedge clk);
    if (ndac_w !== 1'b1) stall("accept");
    {dav_p, dio_p, eoi_p} = '0;
    {nrfd_p, ndac_p} = 2'h3;
    repeat (3) @(negedge clk);
  endtask
  task automatic recv_byte(input int slow, output logic [7:0] d, output logic last);
    @(negedge clk);
    atn_p = 1'b0;
    nrfd_p = 1'b0;
    for (int i = 0; i < 4000 && dav_w !== 1'b0; i++) @(negedge clk);
    if (dav_w !== 1'b0) stall("data valid");
    nrfd_p = 1'b1;
    d = ~dio_w;
    last = ~eoi_w;
    repeat (slow) @(negedge clk);
    ndac_p = 1'b0;
    for (int i = 0; i < 4000 && dav_w !== 1'b1; i++) @(negedge clk);
    if (dav_w !== 1'b1) stall("data release");
    ndac_p = 1'b1;
  endtask
endmodule // gii_ctrl_model
`default_nettype wire

// ---- verification/gii_top_test.sv ----
// Self-checking bench of the bus instrument interface against a controller model.
`timescale 1ns/1ps
`default_nettype none
module gii_top_test
  import gii_pkg::*;
();
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         addr_wr = 1'b0;
  logic [5:0]   addr_set = 6'h00;
  logic         tx_valid = 1'b0;
  gii_byte_type tx_byte = '0;
  logic         rx_ready = 1'b0;
  logic         svc_req = 1'b0;
  logic [7:0]   stb_in = 8'h00;
  logic [7:0]   dio_out, dio_oe_n, c_dio;
  logic         dav_out, dav_oe_n, nrfd_out, nrfd_oe_n, ndac_out, ndac_oe_n;
  logic         eoi_out, eoi_oe_n, srq_out, srq_oe_n, c_dav, c_nrfd, c_ndac;
  logic         c_eoi, c_atn, c_ifc, c_ren, tx_ready, rx_valid, dev_clear, trigger;
  logic         remote, panel_lock, talk_active, listen_active, talk_only;
  gii_byte_type rx_byte;
  int           fail_count, total_checks, clr_n, trg_n, cyc;
  wire logic [7:0] dio_w = (dio_oe_n | dio_out) & ~c_dio;
  wire logic       dav_w = (dav_oe_n | dav_out) & ~c_dav;
  wire logic       nrfd_w = (nrfd_oe_n | nrfd_out) & ~c_nrfd;
  wire logic       ndac_w = (ndac_oe_n | ndac_out) & ~c_ndac;
  wire logic       eoi_w = (eoi_oe_n | eoi_out) & ~c_eoi;

  always #5 clk = ~clk;

  gii_ctrl_model ctrl (.clk, .dio_w, .dav_w, .nrfd_w, .ndac_w, .eoi_w, .dio_p(c_dio),
    .dav_p(c_dav), .nrfd_p(c_nrfd), .ndac_p(c_ndac), .eoi_p(c_eoi), .atn_p(c_atn),
    .ifc_p(c_ifc), .ren_p(c_ren));
  gii_top uut (.clk, .rst_n, .dio_in(dio_w), .dio_out, .dio_oe_n, .dav_in(dav_w),
    .dav_out, .dav_oe_n, .nrfd_in(nrfd_w), .nrfd_out, .nrfd_oe_n, .ndac_in(ndac_w),
    .ndac_out, .ndac_oe_n, .eoi_in(eoi_w), .eoi_out, .eoi_oe_n, .srq_out, .srq_oe_n,
    .atn_in(!c_atn), .ifc_in(!c_ifc), .ren_in(!c_ren), .addr_wr, .addr_set, .tx_valid,
    .tx_byte, .tx_ready, .rx_valid, .rx_byte, .rx_ready, .svc_req, .stb_in, .dev_clear,
    .trigger, .remote, .panel_lock, .talk_active, .listen_active, .talk_only);

  // Pulses are counted at the falling edge, clear of the register update.
  always @(negedge clk) begin
    if (dev_clear === 1'b1) clr_n++;
    if (trigger === 1'b1) trg_n++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      $display("mismatch %0t run too long", $time);
      end_of_test;
    end
  end

  task automatic end_of_test;
    fail_count += ctrl.stalls;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic st(input logic [2:0] e);
    chk({6'h00, talk_active, listen_active, remote}, {6'h00, e}, "state");
  endtask
  task automatic cmd(input logic [7:0] c);
    ctrl.send_byte(1'b1, c, 1'b0);
  endtask
  task automatic set_addr(input logic [5:0] a);
    @(negedge clk);
    addr_set = a;
    addr_wr = 1'b1;
    @(negedge clk);
    addr_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic push(input logic [8:0] b);
    @(negedge clk);
    tx_valid = 1'b1;
    tx_byte = b;
    for (int i = 0; i < 9000 && tx_ready !== 1'b1; i++) @(negedge clk);
    chk({8'h00, tx_ready}, 9'h001, "tx ready");
    @(negedge clk);
    tx_valid = 1'b0;
  endtask
  task automatic take(input logic [8:0] e);
    for (int i = 0; i < 4000 && rx_valid !== 1'b1; i++) @(negedge clk);
    chk({8'h00, rx_valid}, 9'h001, "rx valid");
    chk(rx_byte, e, "rx byte");
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask
  task automatic get(input int slow, input logic [8:0] e);
    logic [7:0] d;
    logic       l;
    ctrl.recv_byte(slow, d, l);
    chk({l, d}, e, "tx byte");
  endtask

  task automatic t_remote;
    cmd(8'h3c);
    st(3'h2);
    cmd(8'h3f);
    ctrl.ren_p = 1'b1;
    repeat (3) @(negedge clk);
    st(3'h0);
    cmd(8'h3c);
    st(3'h3);
    chk({8'h00, panel_lock}, 9'h000, "lock");
    cmd(8'h11);
    chk({8'h00, panel_lock}, 9'h001, "lock");
    cmd(8'h01);
    st(3'h2);
    cmd(8'h3c);
    ctrl.ren_p = 1'b0;
    repeat (3) @(negedge clk);
    st(3'h2);
    cmd(8'h3f);
  endtask
  task automatic t_rx;
    ctrl.send_byte(1'b0, 8'ha5, 1'b0);
    chk({8'h00, rx_valid}, 9'h000, "unaddressed");
    cmd(8'h3c);
    ctrl.send_byte(1'b0, 8'h12, 1'b0);
    take(9'h012);
    ctrl.send_byte(1'b0, 8'h34, 1'b1);
    // The second byte must wait while the first is still unread.
    fork
      ctrl.send_byte(1'b0, 8'h56, 1'b0);
      begin
        repeat (60) @(negedge clk);
        take(9'h134);
        take(9'h056);
      end
    join
    cmd(8'h5c);
    st(3'h4);
    cmd(8'h3c);
    st(3'h2);
    cmd(8'h3f);
  endtask
  task automatic t_talk;
    push(9'h081);
    push(9'h142);
    repeat (300) @(negedge clk);
    chk({dio_oe_n, dav_oe_n}, 9'h1ff, "quiet");
    cmd(8'h5c);
    get(0, 9'h081);
    get(25, 9'h142);
    cmd(8'h5f);
    chk({dio_oe_n, dav_oe_n}, 9'h1ff, "released");
  endtask
  task automatic t_fifo;
    for (int i = 0; i < 32; i++) push({1'b0, 8'(i)});
    chk({8'h00, tx_ready}, 9'h000, "full");
    cmd(8'h5c);
    for (int i = 0; i < 32; i++) get(i % 3 * 15, {1'b0, 8'(i)});
    cmd(8'h5f);
    chk({8'h00, tx_ready}, 9'h001, "empty");
  endtask
  task automatic t_clear;
    int c0;
    int t0;
    c0 = clr_n;
    t0 = trg_n;
    cmd(8'h3c);
    cmd(8'h04);
    cmd(8'h08);
    cmd(8'h3f);
    cmd(8'h04);
    cmd(8'h08);
    chk(9'(clr_n - c0), 9'h001, "sdc");
    chk(9'(trg_n - t0), 9'h001, "get");
    push(9'h077);
    cmd(8'h14);
    chk(9'(clr_n - c0), 9'h002, "dcl");
    cmd(8'h5c);
    ctrl.atn_p = 1'b0;
    repeat (300) @(negedge clk);
    chk({dio_oe_n, dav_oe_n}, 9'h1ff, "flushed");
    cmd(8'h5f);
  endtask
  task automatic t_poll;
    logic [7:0] d;
    logic       l;
    stb_in = 8'h85;
    svc_req = 1'b1;
    @(negedge clk);
    svc_req = 1'b0;
    @(negedge clk);
    chk({8'h00, srq_oe_n}, 9'h000, "srq");
    cmd(8'h18);
    cmd(8'h5c);
    ctrl.recv_byte(0, d, l);
    chk({1'b0, d}, 9'h0c5, "status");
    // The pending flag drops one edge after the byte is accepted.
    @(negedge clk);
    chk({8'h00, srq_oe_n}, 9'h001, "srq");
    ctrl.recv_byte(0, d, l);
    chk({1'b0, d}, 9'h085, "status");
    cmd(8'h19);
    cmd(8'h5f);
  endtask
  task automatic t_misc;
    ctrl.ren_p = 1'b1;
    cmd(8'h3c);
    cmd(8'h05);
    cmd(8'h7c);
    ctrl.eoi_p = 1'b1;
    repeat (20) @(negedge clk);
    chk({dio_oe_n, 1'b1}, 9'h1ff, "identify");
    ctrl.eoi_p = 1'b0;
    st(3'h3);
    cmd(8'h5c);
    ctrl.ifc_p = 1'b1;
    repeat (5) @(negedge clk);
    ctrl.ifc_p = 1'b0;
    @(negedge clk);
    st(3'h0);
    ctrl.ren_p = 1'b0;
  endtask
  task automatic t_addr;
    set_addr(6'h1f);
    cmd(8'h3c);
    st(3'h2);
    cmd(8'h3f);
    set_addr(6'h1e);
    cmd(8'h3e);
    st(3'h2);
    cmd(8'h3f);
    for (int a = 40; a <= 43; a++) begin
      set_addr(6'(a));
      chk({8'h00, talk_only}, 9'h001, "talk only");
    end
    push(9'h133);
    get(0, 9'h133);
    set_addr(6'h1c);
    chk({8'h00, talk_only}, 9'h000, "talk only");
  endtask

  initial begin
    repeat (8) @(negedge clk);
    chk({dio_oe_n, srq_oe_n}, 9'h1ff, "idle");
    chk({3'h0, dav_oe_n, nrfd_oe_n, ndac_oe_n, eoi_oe_n, tx_ready, talk_only},
      9'h03e, "idle");
    rst_n = 1'b1;
    t_remote;
    t_rx;
    t_talk;
    t_fifo;
    t_clear;
    t_poll;
    t_misc;
    t_addr;
    end_of_test;
  end
endmodule // gii_top_test
`default_nettype wire
